// *** rtl/rst_irq_defs.vh ***
// constants for the reset and interrupt control block
`ifndef RST_IRQ_DEFS_VH
`define RST_IRQ_DEFS_VH

// i/o space addresses
`define ADDR_TIMER_FLAG 6'h38
`define ADDR_TIMER_MASK 6'h39
`define ADDR_EXT_FLAG 6'h3a
`define ADDR_GEN_IRQ_EN 6'h3b
`define ADDR_RESET_CAUSE 6'h34

// field positions
`define BIT_EXT_ENABLE 3'd6
`define BIT_EXT_FLAG 3'd6
`define BIT_TOV_ENABLE 3'd1
`define BIT_TOV_FLAG 3'd1
`define BIT_PIN_CAUSE 3'd1
`define BIT_POWER_CAUSE 3'd0

// reset values
`define RESET_REG8 8'h00
`define RESET_PIN_CAUSE 1'b0

// program vectors
`define VEC_RESET 10'h000
`define VEC_EXT 10'h001
`define VEC_TIMER 10'h002

// start-up delay: one watchdog oscillator cycle (16 us at 5 V)
`define STARTUP_DELAY_NS 16000
`define CLK_PERIOD_NS 8
`define STARTUP_CYCLES ((`STARTUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CNT_W 12

`endif

// *** rtl/pin_reset_sync.v ***
// external reset pin: asynchronous assert, synchronised release
`timescale 1ns/1ps
module pin_reset_sync (
    input wire sys_clk,
    input wire reset_pin_n,
    output reg pin_reset
);
    reg stage1;

    // assert without clock, release after two edges
    always @(posedge sys_clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            stage1 <= 1'b1;
            pin_reset <= 1'b1;
        end else begin
            stage1 <= 1'b0;
            pin_reset <= stage1;
        end
    end
endmodule

// *** rtl/startup_delay_timer.v ***
// start-up delay counter shared by all reset sources
`timescale 1ns/1ps
`include "rst_irq_defs.vh"
module startup_delay_timer (
    input wire sys_clk,
    input wire restart,
    output reg busy
);
    localparam integer LOAD_FULL = `STARTUP_CYCLES;
    localparam [`STARTUP_CNT_W-1:0] LOAD = LOAD_FULL[`STARTUP_CNT_W-1:0];
    reg [`STARTUP_CNT_W-1:0] count;

    always @(posedge sys_clk) begin
        if (restart) begin
            count <= LOAD;
            busy <= 1'b1;
        end else if (count != {`STARTUP_CNT_W{1'b0}}) begin
            count <= count - 1'b1;
            busy <= (count != {{(`STARTUP_CNT_W-1){1'b0}}, 1'b1});
        end else begin
            busy <= 1'b0;
        end
    end
endmodule

// *** rtl/reset_and_interrupt_control.v ***
// reset combining, reset cause record and two-source interrupt arbiter
// Summary of operation
// R1 - a source is taken only when its enable and the global enable are set
// R2 - vectors: reset at 000, pin request at 001, timer overflow at 002
// R3 - lowest vector wins: reset, then pin request, then timer overflow
// R4 - reset pin low over 50 ns resets, even with no clock
// R5 - reset loads all registers with initial values; fetch starts at 000
// R6 - after power-on the core is held for one start-up delay
// R7 - on reset pin release the delay starts; core freed when it expires
// R8 - watchdog pulse resets; delay counts from the pulse's falling edge
// R9 - pin reset sets cause bit 1; watchdog leaves it alone
// R10 - power-on sets cause bit 0; other resets leave it alone
// R11 - cause register bits 7 to 2 read as zero
// R12 - software reads then clears both cause flags early after start-up
// R13 - accepting an interrupt clears global enable; return sets it again
// R14 - vectoring clears the pending flag of the served source
// R15 - writing one clears a flag; writing zero leaves it
// R16 - a flag raised while its source is disabled stays set
// R17 - flags raised with global enable clear stay pending, served by priority
// R18 - in low-level mode the pin request latches nothing, pending while low
// R19 - the core status register is neither saved nor restored
// R20 - software puts a jump at the reset vector
// R21 - vector runs at least 4 cycles after its flag is set
// R22 - pin event sets flag bit 6; cleared by vectoring or writing one
// R23 - overflow sets flag bit 1; served only if bit 1 enable and global set
// R24 - after return one instruction runs before another interrupt
// R25 - all reset sources merge, core held until shared delay expires
// R26 - reset pin release is synchronised before the delay counter starts
`timescale 1ns/1ps
`include "rst_irq_defs.vh"
module reset_and_interrupt_control (
    input wire sys_clk,
    input wire rst,
    input wire reset_pin_n,
    input wire wdt_timeout,
    input wire ext_pin_event,
    input wire ext_pin_low,
    input wire ext_low_level_mode,
    input wire timer_overflow_source,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire gie_set,
    input wire gie_clear,
    input wire irq_ack,
    input wire return_from_interrupt,
    input wire instr_retire,
    output reg [7:0] io_rdata,
    output reg core_reset,
    output reg global_enable,
    output reg irq_request,
    output reg [9:0] irq_vector
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_REQ = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    wire pin_reset;
    wire delay_busy;
    wire any_reset;

    reg ext_enable;
    reg ext_flag;
    reg tov_enable;
    reg tov_flag;
    reg power_on_cause_flag;
    reg pin_reset_cause_flag;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [9:0] next_vector;
    reg next_request;

    wire ext_pending;
    wire ext_live;
    wire tov_live;
    wire take_ext;
    wire take_tov;
    wire wr_ext_flag;
    wire wr_tov_flag;
    wire [7:0] read_mux;

    function [7:0] bit_at;
        input value;
        input [2:0] pos;
        begin
            bit_at = {7'h00, value} << pos;
        end
    endfunction

    function hit;
        input [5:0] addr;
        input [5:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    pin_reset_sync u_pin_sync (
        .sys_clk(sys_clk),
        .reset_pin_n(reset_pin_n),
        .pin_reset(pin_reset)
    ); // [R26]

    // any source restarts the shared delay; it runs out after they drop
    assign any_reset = rst | pin_reset | wdt_timeout; // [R25] [R8]

    startup_delay_timer u_delay (
        .sys_clk(sys_clk),
        .restart(any_reset),
        .busy(delay_busy)
    ); // [R6] [R7] [R8]

    // core held from any source until the delay expires
    always @(posedge sys_clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            core_reset <= 1'b1; // [R4]
        end else begin
            core_reset <= any_reset | delay_busy; // [R25] [R7]
        end
    end

    // reset cause flags survive the core reset
    always @(posedge sys_clk) begin
        if (rst) begin
            power_on_cause_flag <= 1'b1; // [R10]
            pin_reset_cause_flag <= `RESET_PIN_CAUSE;
        end else if (pin_reset) begin
            pin_reset_cause_flag <= 1'b1; // [R9]
        end else if (!core_reset && io_wr && hit(io_addr, `ADDR_RESET_CAUSE)) begin
            power_on_cause_flag <= io_wdata[`BIT_POWER_CAUSE];
            pin_reset_cause_flag <= io_wdata[`BIT_PIN_CAUSE];
        end
    end

    assign wr_ext_flag = io_wr & hit(io_addr, `ADDR_EXT_FLAG) & io_wdata[`BIT_EXT_FLAG];
    assign wr_tov_flag = io_wr & hit(io_addr, `ADDR_TIMER_FLAG) & io_wdata[`BIT_TOV_FLAG];

    // pending test per source
    assign ext_pending = ext_low_level_mode ? ext_pin_low : ext_flag; // [R18]
    assign ext_live = ext_pending & ext_enable; // [R1]
    assign tov_live = tov_flag & tov_enable; // [R1] [R23]

    // vectoring clears only the flag of the source that was served
    assign take_ext = (state == ST_REQ) & irq_ack & (irq_vector == `VEC_EXT);
    assign take_tov = (state == ST_REQ) & irq_ack & (irq_vector == `VEC_TIMER);

    // enable registers and flags; all return to initial values in reset
    always @(posedge sys_clk) begin
        if (core_reset) begin
            ext_enable <= 1'b0; // [R5]
            tov_enable <= 1'b0;
            ext_flag <= 1'b0;
            tov_flag <= 1'b0;
        end else begin
            if (io_wr && hit(io_addr, `ADDR_GEN_IRQ_EN)) begin
                ext_enable <= io_wdata[`BIT_EXT_ENABLE];
            end
            if (io_wr && hit(io_addr, `ADDR_TIMER_MASK)) begin
                tov_enable <= io_wdata[`BIT_TOV_ENABLE];
            end
            // new event wins over a clear in the same cycle
            if (ext_pin_event && !ext_low_level_mode) begin
                ext_flag <= 1'b1; // [R22] [R16] [R17]
            end else if (wr_ext_flag || take_ext || ext_low_level_mode) begin
                ext_flag <= 1'b0; // [R15] [R14] [R18]
            end
            if (timer_overflow_source) begin
                tov_flag <= 1'b1; // [R23] [R16] [R17]
            end else if (wr_tov_flag || take_tov) begin
                tov_flag <= 1'b0; // [R15] [R14]
            end
        end
    end

    // global enable: only the I bit lives here, rest of status is the core's
    always @(posedge sys_clk) begin
        if (core_reset) begin
            global_enable <= 1'b0;
        end else if ((state == ST_REQ) && irq_ack) begin
            global_enable <= 1'b0; // [R13]
        end else if (return_from_interrupt || gie_set) begin
            global_enable <= 1'b1; // [R13] [R19]
        end else if (gie_clear) begin
            global_enable <= 1'b0;
        end
    end

    // arbiter: fixed priority by vector address
    always @* begin
        next_state = state;
        next_vector = irq_vector;
        next_request = 1'b0;
        case (state)
            ST_IDLE: begin
                if (return_from_interrupt) begin
                    next_state = ST_HOLD; // [R24]
                end else if (global_enable && !gie_clear && ext_live) begin
                    next_state = ST_REQ;
                    next_vector = `VEC_EXT; // [R2] [R3]
                    next_request = 1'b1;
                end else if (global_enable && !gie_clear && tov_live) begin
                    next_state = ST_REQ;
                    next_vector = `VEC_TIMER; // [R2] [R3]
                    next_request = 1'b1;
                end
            end
            ST_REQ: begin
                if (irq_ack) begin
                    next_state = ST_IDLE;
                end else if (!global_enable || gie_clear) begin
                    next_state = ST_IDLE;
                end else if (ext_live) begin
                    next_vector = `VEC_EXT; // [R3] [R17]
                    next_request = 1'b1;
                end else if (tov_live) begin
                    next_vector = `VEC_TIMER; // [R3] [R17]
                    next_request = 1'b1;
                end else begin
                    next_state = ST_IDLE; // [R18]
                end
            end
            ST_HOLD: begin
                // one instruction of the interrupted program first
                if (instr_retire) begin
                    next_state = ST_IDLE; // [R24]
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (core_reset) begin
            state <= ST_IDLE;
            irq_request <= 1'b0;
            irq_vector <= `VEC_RESET; // [R2] [R5]
        end else begin
            state <= next_state;
            irq_request <= next_request; // [R21]
            irq_vector <= next_vector;
        end
    end

    // register read; unused bits read zero
    assign read_mux = hit(io_addr, `ADDR_GEN_IRQ_EN) ? bit_at(ext_enable, `BIT_EXT_ENABLE) :
                      hit(io_addr, `ADDR_EXT_FLAG) ? bit_at(ext_flag, `BIT_EXT_FLAG) :
                      hit(io_addr, `ADDR_TIMER_MASK) ? bit_at(tov_enable, `BIT_TOV_ENABLE) :
                      hit(io_addr, `ADDR_TIMER_FLAG) ? bit_at(tov_flag, `BIT_TOV_FLAG) :
                      hit(io_addr, `ADDR_RESET_CAUSE) ?
                          (bit_at(pin_reset_cause_flag, `BIT_PIN_CAUSE) |
                           bit_at(power_on_cause_flag, `BIT_POWER_CAUSE)) : // [R11]
                      `RESET_REG8;

    always @(posedge sys_clk) begin
        if (rst) begin
            io_rdata <= `RESET_REG8;
        end else if (io_rd) begin
            io_rdata <= read_mux;
        end
    end
endmodule

// *** verif/rst_irq_chk.sv ***
// assertion checker for the reset and interrupt control block
`timescale 1ns/1ps
module rst_irq_chk (
    input wire sys_clk,
    input wire rst,
    input wire reset_pin_n,
    input wire wdt_timeout,
    input wire [5:0] io_addr,
    input wire io_rd,
    input wire irq_ack,
    input wire return_from_interrupt,
    input wire [7:0] io_rdata,
    input wire core_reset,
    input wire global_enable,
    input wire irq_request,
    input wire [9:0] irq_vector
);
    logic [15:0] hold_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // held cycles since the last reset source went away
    always @(posedge sys_clk) begin
        if (rst || !reset_pin_n || wdt_timeout || !core_reset) begin
            hold_cnt <= 16'h0000;
        end else begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end
    sequence s_ack;
        irq_request && irq_ack;
    endsequence
    sequence s_ret;
        return_from_interrupt && !core_reset;
    endsequence
    chk_ack_drops_req: assert property (s_ack |=> !irq_request && !global_enable)
        else $error("request or global enable stayed up after ack");
    chk_ret_sets_gie: assert property (s_ret |=> global_enable)
        else $error("return did not set global enable");
    chk_ret_one_instr: assert property (s_ret |=> !irq_request [*2])
        else $error("request right after return");
    chk_gie_gates_req: assert property (!global_enable ##1 !global_enable |-> !irq_request)
        else $error("request with global enable clear");
    chk_vec_legal: assert property (irq_request |-> irq_vector == 10'h001 || irq_vector == 10'h002)
        else $error("illegal vector");
    chk_reset_quiet: assert property (core_reset && $past(core_reset) |-> !irq_request && irq_vector == 10'h000)
        else $error("activity while core held");
    chk_startup_hold: assert property ($fell(core_reset) |-> hold_cnt >= 16'h07d0 && hold_cnt <= 16'h07da)
        else $error("core released at wrong time");
    chk_pin_async: assert property (!reset_pin_n |-> core_reset)
        else $error("pin low without core reset");
    chk_wdt_resets: assert property (wdt_timeout |-> ##[1:2] core_reset)
        else $error("watchdog did not reset");
    chk_cause_res: assert property ($past(io_rd) && $past(io_addr) == 6'h34 |-> io_rdata[7:2] == 6'h00)
        else $error("cause reserved bits set");
endmodule

// *** verif/core_model.sv ***
// processor core model: acks vectors, returns, retires one instruction
`timescale 1ns/1ps
module core_model (
    input wire sys_clk,
    input wire core_reset,
    input wire irq_request,
    input wire [3:0] ack_lag,
    output reg irq_ack,
    output reg return_from_interrupt,
    output reg instr_retire
);
    reg [3:0] wait_cnt = 4'h0;
    reg [1:0] phase = 2'h0;
    initial begin
        irq_ack = 1'b0;
        return_from_interrupt = 1'b0;
        instr_retire = 1'b0;
    end
    always @(posedge sys_clk) begin
        irq_ack <= 1'b0;
        return_from_interrupt <= 1'b0;
        instr_retire <= 1'b0;
        if (core_reset) begin
            phase <= 2'h0;
            wait_cnt <= 4'h0;
        end else if (phase == 2'h0) begin
            // ack only while the request stands, after a chosen lag
            if (irq_request && wait_cnt >= ack_lag && !irq_ack) begin
                irq_ack <= 1'b1;
                phase <= 2'h1;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= irq_request ? wait_cnt + 4'h1 : 4'h0;
            end
        end else if (phase == 2'h1) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == 4'h3) begin
                return_from_interrupt <= 1'b1;
                phase <= 2'h2;
            end
        end else begin
            instr_retire <= 1'b1;
            phase <= 2'h0;
            wait_cnt <= 4'h0;
        end
    end
endmodule

// *** verif/tb_reset_and_interrupt_control.sv ***
// self-checking bench for the reset and interrupt control block
`timescale 1ns/1ps
module tb_reset_and_interrupt_control;
    reg sys_clk = 0, rst = 1, reset_pin_n = 1, wdt_timeout = 0, ext_pin_event = 0, ext_pin_low = 0;
    reg ext_low_level_mode = 0, timer_overflow_source = 0, io_wr = 0, io_rd = 0, gie_set = 0, gie_clear = 0;
    reg [5:0] io_addr = 6'h00;
    reg [7:0] io_wdata = 8'h00, v;
    reg [3:0] ack_lag = 4'h0;
    wire irq_ack, return_from_interrupt, instr_retire, core_reset, global_enable, irq_request;
    wire [7:0] io_rdata;
    wire [9:0] irq_vector;
    integer num_errors = 0, tests_run = 0, cycles = 0, seed = 32'h9e77, i;
    reg rd_flag = 0;
    reg [7:0] rd_q[$];
    reg [9:0] vec_q[$];
    always #4 sys_clk = ~sys_clk;
    reset_and_interrupt_control u_dut (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
        .wdt_timeout(wdt_timeout), .ext_pin_event(ext_pin_event), .ext_pin_low(ext_pin_low),
        .ext_low_level_mode(ext_low_level_mode), .timer_overflow_source(timer_overflow_source), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .gie_set(gie_set), .gie_clear(gie_clear),
        .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt), .instr_retire(instr_retire),
        .io_rdata(io_rdata), .core_reset(core_reset), .global_enable(global_enable),
        .irq_request(irq_request), .irq_vector(irq_vector));
    core_model u_core (.sys_clk(sys_clk), .core_reset(core_reset), .irq_request(irq_request), .ack_lag(ack_lag),
        .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt), .instr_retire(instr_retire));
    task cmp8(input [7:0] got, input [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cmp10(input [9:0] got, input [9:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("errors=%0d compares=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("== PASSED =="); else $display("== FAILED ==");
        $finish;
    endtask
    // results are taken off the queues as they appear
    always @(negedge sys_clk) begin
        if (rd_flag) cmp8(io_rdata, rd_q.pop_front());
        rd_flag = io_rd;
        if (irq_ack && irq_request) cmp10(irq_vector, vec_q.pop_front());
    end
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            final_report;
        end
    end
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task wr(input [5:0] a, input [7:0] d);
        tick;
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        tick;
        io_wr = 0;
    endtask
    task rd(input [5:0] a, input [7:0] e);
        tick;
        io_addr = a;
        io_rd = 1;
        rd_q.push_back(e);
        tick;
        io_rd = 0;
    endtask
    task settle;
        for (i = 0; i < 2100 && core_reset !== 1'b0; i = i + 1) tick;
        for (i = 0; i < 80 && vec_q.size() > 0; i = i + 1) tick;
        repeat (8) tick;
        cmp8({7'h00, core_reset}, 8'h00);
        cmp8(vec_q.size(), 8'h00);
    endtask
    initial begin
        repeat (16) tick;
        rst = 0;
        settle;
        rd(6'h34, 8'h01);
        rd(6'h3b, 8'h00);
        rd(6'h20, 8'h00);
        v = $random(seed);
        wr(6'h34, v);
        rd(6'h34, {6'h00, v[1:0]});
        wr(6'h34, 8'h00);
        wr(6'h3b, 8'h40);
        reset_pin_n = 0;
        #2;
        cmp8({7'h00, core_reset}, 8'h01);
        tick;
        reset_pin_n = 1;
        settle;
        rd(6'h34, 8'h02);
        rd(6'h3b, 8'h00);
        wdt_timeout = 1;
        tick;
        wdt_timeout = 0;
        settle;
        rd(6'h34, 8'h02);
        wr(6'h3b, 8'h40);
        wr(6'h39, 8'h02);
        ext_pin_event = 1;
        timer_overflow_source = 1;
        tick;
        ext_pin_event = 0;
        timer_overflow_source = 0;
        rd(6'h3a, 8'h40);
        rd(6'h38, 8'h02);
        vec_q.push_back(10'h001);
        vec_q.push_back(10'h002);
        v = $random(seed);
        ack_lag = v[3:0];
        gie_set = 1;
        tick;
        gie_set = 0;
        settle;
        rd(6'h3a, 8'h00);
        rd(6'h38, 8'h00);
        wr(6'h39, 8'h00);
        timer_overflow_source = 1;
        tick;
        timer_overflow_source = 0;
        repeat (4) tick;
        rd(6'h38, 8'h02);
        wr(6'h38, 8'h00);
        rd(6'h38, 8'h02);
        wr(6'h38, 8'h02);
        rd(6'h38, 8'h00);
        timer_overflow_source = 1;
        tick;
        timer_overflow_source = 0;
        vec_q.push_back(10'h002);
        wr(6'h39, 8'h02);
        settle;
        ext_low_level_mode = 1;
        ext_pin_event = 1;
        tick;
        ext_pin_event = 0;
        rd(6'h3a, 8'h00);
        vec_q.push_back(10'h001);
        ext_pin_low = 1;
        for (i = 0; i < 80 && vec_q.size() > 0; i = i + 1) tick;
        ext_pin_low = 0;
        settle;
        ext_low_level_mode = 0;
        gie_clear = 1;
        tick;
        gie_clear = 0;
        cmp8({7'h00, global_enable}, 8'h00);
        tick;
        io_addr = 6'h38;
        io_wdata = 8'h02;
        io_wr = 1;
        timer_overflow_source = 1;
        tick;
        io_wr = 0;
        timer_overflow_source = 0;
        repeat (4) tick;
        rd(6'h38, 8'h02);
        vec_q.push_back(10'h002);
        gie_set = 1;
        tick;
        gie_set = 0;
        settle;
        rd(6'h38, 8'h00);
        final_report;
    end
endmodule
bind reset_and_interrupt_control rst_irq_chk u_chk (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .wdt_timeout(wdt_timeout), .io_addr(io_addr), .io_rd(io_rd), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt), .io_rdata(io_rdata), .core_reset(core_reset),
    .global_enable(global_enable), .irq_request(irq_request), .irq_vector(irq_vector));
